/* File: core/tmps_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tmps_timer
    import tmps_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic INSTR_CYCLE,
    input wire logic SLEEP,
    input wire logic EXT_COUNT_INPUT,
    input wire logic WDT_BASE_TICK,
    input wire logic WATCHDOG_CLEAR_INSTR,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic WDT_TICK,
    output logic WDT_CLEAR,
    output logic IRQ
);
    tmps_state_t s;
    tmps_state_t next_s;
    tmps_bus_t bus;

    function automatic logic [7:0] ratio_mask(input logic [2:0] ps,
                                              input logic to_wdt);
        logic [8:0] m;
        m = (9'h001 << ps) << !to_wdt;
        return 8'(m - 9'h001);
    endfunction : ratio_mask

    logic css;
    logic edge_fall;
    logic to_wdt;
    logic [7:0] mask;
    logic ext_edge;
    logic event_in;
    logic pre_term;
    logic advance;
    logic count_wr;

    always_comb begin
        bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
        css = s.option[TMPS_CSS_BIT];
        edge_fall = s.option[TMPS_EDGE_BIT];
        to_wdt = s.option[TMPS_PSA_BIT];
        mask = ratio_mask(s.option[2:0], to_wdt);
        // ext_sync[0] only feeds ext_sync[1]; edge taken on [2:1]
        ext_edge = edge_fall ? (s.ext_sync[2] & ~s.ext_sync[1])
                             : (~s.ext_sync[2] & s.ext_sync[1]);
        event_in = css ? ext_edge : INSTR_CYCLE;
        count_wr = bus.wr && bus.addr == TMPS_ADDR_COUNT;
        pre_term = (s.prescale & mask) == mask;
        advance = 1'b0;
        next_s = s;
        next_s.ext_sync = {s.ext_sync[1:0], EXT_COUNT_INPUT};
        next_s.wdt_tick = 1'b0;
        next_s.wdt_clear = 1'b0;
        next_s.rdata = 8'h00;
        if (INSTR_CYCLE && s.inhibit != 2'h0) begin
            next_s.inhibit = s.inhibit - 2'h1;
        end
        // one prescaler shared: only the assigned user sees its ticks
        if (!to_wdt) begin
            if (event_in && !SLEEP && s.inhibit == 2'h0) begin
                next_s.prescale = s.prescale + 8'h01;
                if (pre_term) begin
                    advance = 1'b1;
                    next_s.prescale = 8'h00;
                end
            end
        end else begin
            if (event_in && !SLEEP && s.inhibit == 2'h0) begin
                advance = 1'b1;
            end
            if (WDT_BASE_TICK) begin
                next_s.prescale = s.prescale + 8'h01;
                if (pre_term) begin
                    next_s.wdt_tick = 1'b1;
                    next_s.prescale = 8'h00;
                end
            end
            if (WATCHDOG_CLEAR_INSTR) begin
                next_s.prescale = 8'h00;
                next_s.wdt_clear = 1'b1;
            end
        end
        if (advance) begin
            next_s.count = s.count + 8'h01;
            if (s.count == TMPS_COUNT_MAX) begin
                next_s.intctl[TMPS_OVF_FLAG_BIT] = 1'b1;
                next_s.irq_status = 1'b1;
            end
        end
        if (bus.wr) begin
            case (bus.addr)
                TMPS_ADDR_COUNT: begin
                    next_s.count = bus.wdata;
                    next_s.inhibit = TMPS_INHIBIT_CYCLES;
                    if (!to_wdt) begin
                        next_s.prescale = 8'h00;
                    end
                end
                TMPS_ADDR_OPTION: next_s.option = bus.wdata;
                TMPS_ADDR_INTCTL, TMPS_ADDR_INTCTL_HI: begin
                    // set from overflow in the same cycle wins
                    next_s.intctl = bus.wdata;
                    if (advance && s.count == TMPS_COUNT_MAX) begin
                        next_s.intctl[TMPS_OVF_FLAG_BIT] = 1'b1;
                    end
                end
                TMPS_ADDR_PORTA_DIR: next_s.porta_dir = bus.wdata[5:0];
                TMPS_ADDR_INT_ENABLE: next_s.irq_enable = bus.wdata[0];
                TMPS_ADDR_INT_CLEAR: begin
                    if (bus.wdata[0] &&
                        !(advance && s.count == TMPS_COUNT_MAX)) begin
                        next_s.irq_status = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                TMPS_ADDR_COUNT: next_s.rdata = s.count;
                TMPS_ADDR_OPTION: next_s.rdata = s.option;
                TMPS_ADDR_INTCTL, TMPS_ADDR_INTCTL_HI:
                    next_s.rdata = s.intctl;
                TMPS_ADDR_PORTA_DIR: next_s.rdata = {2'h0, s.porta_dir};
                TMPS_ADDR_INT_STATUS: next_s.rdata = {7'h00, s.irq_status};
                TMPS_ADDR_INT_ENABLE: next_s.rdata = {7'h00, s.irq_enable};
                default: next_s.rdata = 8'h00;
            endcase
        end
        if (RST) begin
            next_s = '0;
            next_s.option = TMPS_OPTION_RESET;
            next_s.intctl = TMPS_INTCTL_RESET;
            next_s.porta_dir = TMPS_PORTA_DIR_RESET;
        end
    end

    always_ff @(posedge CLK) begin
        s <= next_s;
    end

    assign RDATA = s.rdata;
    assign WDT_TICK = s.wdt_tick;
    assign WDT_CLEAR = s.wdt_clear;
    // status-register event path and cpu-facing gated flag both drive irq
    assign IRQ = (s.irq_status & s.irq_enable) |
                 (s.intctl[TMPS_OVF_FLAG_BIT] & s.intctl[TMPS_OVF_IE_BIT]);

    a_wrap_sets_flag: assert property (@(posedge CLK) disable iff (RST)
        (advance && s.count == 8'hFF && !count_wr) |=>
        (s.count == 8'h00 && s.intctl[2]))
        else $error("wrap did not set overflow flag");
    a_write_inhibit: assert property (@(posedge CLK) disable iff (RST)
        (count_wr && !css) |=> (s.count == $past(WDATA)) ##0
        (s.inhibit == 2'h2))
        else $error("count write did not arm inhibit");
    a_inhibit_holds: assert property (@(posedge CLK) disable iff (RST)
        (s.inhibit != 2'h0 && !count_wr) |=> $stable(s.count))
        else $error("count moved during inhibit");
    a_timer_step: assert property (@(posedge CLK) disable iff (RST)
        (!css && to_wdt && INSTR_CYCLE && !SLEEP && s.inhibit == 2'h0
         && !bus.wr) |=> s.count == $past(s.count) + 8'h01)
        else $error("timer mode did not step");
    a_sleep_stops: assert property (@(posedge CLK) disable iff (RST)
        (SLEEP && !bus.wr) |=> $stable(s.count))
        else $error("count moved in sleep");
    a_prescale_clear: assert property (@(posedge CLK) disable iff (RST)
        (count_wr && !to_wdt) |=> s.prescale == 8'h00)
        else $error("prescaler not cleared by count write");
    a_wdt_clear_op: assert property (@(posedge CLK) disable iff (RST)
        (to_wdt && WATCHDOG_CLEAR_INSTR && !bus.wr) |=>
        (s.prescale == 8'h00 && WDT_CLEAR))
        else $error("watchdog clear missed");
    a_irq_masked: assert property (@(posedge CLK) disable iff (RST)
        (!s.intctl[5] && !s.irq_enable) |-> !IRQ)
        else $error("masked interrupt raised");
    a_wdt_ratio: assert property (@(posedge CLK) disable iff (RST)
        (to_wdt && s.option[2:0] == 3'h0 && WDT_BASE_TICK &&
         !WATCHDOG_CLEAR_INSTR && !bus.wr) |=> WDT_TICK)
        else $error("1:1 watchdog ratio failed");

    a_step_by_one: assert property (@(posedge CLK) disable iff (RST)
        (advance && !count_wr) |=> s.count == $past(s.count) + 8'h01)
        else $error("count did not step by one");

    a_hold_no_step: assert property (@(posedge CLK) disable iff (RST)
        (!advance && !count_wr) |=> $stable(s.count))
        else $error("count moved without a step");

    a_status_on_wrap: assert property (@(posedge CLK) disable iff (RST)
        (advance && s.count == TMPS_COUNT_MAX) |=> s.irq_status)
        else $error("wrap did not set status bit");

    a_flag_no_wrap: assert property (@(posedge CLK) disable iff (RST)
        (!s.intctl[TMPS_OVF_FLAG_BIT] && !advance && !bus.wr) |=>
        !s.intctl[TMPS_OVF_FLAG_BIT])
        else $error("flag set without a wrap");

    a_status_sticky: assert property (@(posedge CLK) disable iff (RST)
        (s.irq_status && !(bus.wr && bus.addr == TMPS_ADDR_INT_CLEAR)) |=>
        s.irq_status)
        else $error("status bit cleared by itself");

    a_flag_sticky: assert property (@(posedge CLK) disable iff (RST)
        (s.intctl[TMPS_OVF_FLAG_BIT] && !bus.wr) |=>
        s.intctl[TMPS_OVF_FLAG_BIT])
        else $error("flag cleared by hardware");

    a_status_clear: assert property (@(posedge CLK) disable iff (RST)
        (bus.wr && bus.addr == TMPS_ADDR_INT_CLEAR && bus.wdata[0] &&
         !(advance && s.count == TMPS_COUNT_MAX)) |=> !s.irq_status)
        else $error("status clear ignored");

    a_intctl_write: assert property (@(posedge CLK) disable iff (RST)
        (bus.wr && bus.addr == TMPS_ADDR_INTCTL && !advance) |=>
        s.intctl == $past(WDATA))
        else $error("interrupt control write lost");

    a_intctl_alias: assert property (@(posedge CLK) disable iff (RST)
        (bus.wr && bus.addr == TMPS_ADDR_INTCTL_HI && !advance) |=>
        s.intctl == $past(WDATA))
        else $error("interrupt control alias write lost");

    a_irq_from_flag: assert property (@(posedge CLK) disable iff (RST)
        (s.intctl[TMPS_OVF_FLAG_BIT] && s.intctl[TMPS_OVF_IE_BIT]) |-> IRQ)
        else $error("enabled flag did not raise interrupt");

    a_irq_from_stat: assert property (@(posedge CLK) disable iff (RST)
        (s.irq_status && s.irq_enable) |-> IRQ)
        else $error("enabled status did not raise interrupt");

    a_irq_has_cause: assert property (@(posedge CLK) disable iff (RST)
        IRQ |-> ((s.intctl[TMPS_OVF_FLAG_BIT] && s.intctl[TMPS_OVF_IE_BIT])
        || (s.irq_status && s.irq_enable)))
        else $error("interrupt raised without cause");

    a_option_write: assert property (@(posedge CLK) disable iff (RST)
        (bus.wr && bus.addr == TMPS_ADDR_OPTION) |=> s.option == $past(WDATA))
        else $error("option write lost");

    a_option_hold: assert property (@(posedge CLK) disable iff (RST)
        !(bus.wr && bus.addr == TMPS_ADDR_OPTION) |=> $stable(s.option))
        else $error("option changed without write");

    a_read_count: assert property (@(posedge CLK) disable iff (RST)
        (bus.rd && bus.addr == TMPS_ADDR_COUNT) |=> RDATA == $past(s.count))
        else $error("count read returned wrong value");

    a_read_option: assert property (@(posedge CLK) disable iff (RST)
        (bus.rd && bus.addr == TMPS_ADDR_OPTION) |=> RDATA == $past(s.option))
        else $error("option read returned wrong value");

    a_read_intctl: assert property (@(posedge CLK) disable iff (RST)
        (bus.rd && bus.addr == TMPS_ADDR_INTCTL) |=> RDATA == $past(s.intctl))
        else $error("interrupt control read wrong");

    a_read_idle: assert property (@(posedge CLK) disable iff (RST)
        !bus.rd |=> RDATA == 8'h00)
        else $error("read data not zero when idle");

    a_clear_wr_only: assert property (@(posedge CLK) disable iff (RST)
        (bus.rd && bus.addr == TMPS_ADDR_INT_CLEAR) |=> RDATA == 8'h00)
        else $error("write-only register readable");

    a_inhibit_arm: assert property (@(posedge CLK) disable iff (RST)
        count_wr |=> s.inhibit == TMPS_INHIBIT_CYCLES)
        else $error("inhibit not armed");

    a_inhibit_down: assert property (@(posedge CLK) disable iff (RST)
        (s.inhibit != 2'h0 && INSTR_CYCLE && !count_wr) |=>
        s.inhibit == $past(s.inhibit) - 2'h1)
        else $error("inhibit did not count down");

    a_inhibit_idle: assert property (@(posedge CLK) disable iff (RST)
        (!INSTR_CYCLE && !count_wr) |=> $stable(s.inhibit))
        else $error("inhibit moved without a cycle");

    a_no_step_inhib: assert property (@(posedge CLK) disable iff (RST)
        (s.inhibit != 2'h0) |-> !advance)
        else $error("count stepped while inhibited");

    a_no_step_sleep: assert property (@(posedge CLK) disable iff (RST)
        SLEEP |-> !advance)
        else $error("count stepped in sleep");

    a_sleep_prescale: assert property (@(posedge CLK) disable iff (RST)
        (SLEEP && !to_wdt && !count_wr) |=> $stable(s.prescale))
        else $error("timer prescaler moved in sleep");

    a_pre_step: assert property (@(posedge CLK) disable iff (RST)
        (!to_wdt && event_in && !SLEEP && s.inhibit == 2'h0 && !pre_term
         && !count_wr) |=> s.prescale == $past(s.prescale) + 8'h01)
        else $error("timer prescaler did not step");

    a_term_advances: assert property (@(posedge CLK) disable iff (RST)
        (!to_wdt && event_in && !SLEEP && s.inhibit == 2'h0 && pre_term)
        |-> advance)
        else $error("terminal count did not advance");

    a_step_at_term: assert property (@(posedge CLK) disable iff (RST)
        (!to_wdt && advance) |-> pre_term)
        else $error("timer advanced before terminal count");

    a_wdt_quiet: assert property (@(posedge CLK) disable iff (RST)
        !to_wdt |=> (!WDT_TICK && !WDT_CLEAR))
        else $error("watchdog outputs active on timer");

    a_direct_count: assert property (@(posedge CLK) disable iff (RST)
        (to_wdt && event_in && !SLEEP && s.inhibit == 2'h0) |-> advance)
        else $error("direct event did not advance");

    a_wdt_tick_term: assert property (@(posedge CLK) disable iff (RST)
        (to_wdt && WDT_BASE_TICK && pre_term) |=> WDT_TICK)
        else $error("postscaler terminal missed");

    a_wdt_tick_cause: assert property (@(posedge CLK) disable iff (RST)
        !(to_wdt && WDT_BASE_TICK && pre_term) |=> !WDT_TICK)
        else $error("watchdog tick without terminal");

    a_wdt_clr_cause: assert property (@(posedge CLK) disable iff (RST)
        !(to_wdt && WATCHDOG_CLEAR_INSTR) |=> !WDT_CLEAR)
        else $error("watchdog clear without request");

    a_wdt_pre_step: assert property (@(posedge CLK) disable iff (RST)
        (to_wdt && WDT_BASE_TICK && !pre_term && !WATCHDOG_CLEAR_INSTR) |=>
        s.prescale == $past(s.prescale) + 8'h01)
        else $error("postscaler did not step");

    a_wdt_keeps_pre: assert property (@(posedge CLK) disable iff (RST)
        (count_wr && to_wdt && !WDT_BASE_TICK && !WATCHDOG_CLEAR_INSTR) |=>
        $stable(s.prescale))
        else $error("count write touched watchdog prescaler");

    a_pin_only: assert property (@(posedge CLK) disable iff (RST)
        (css && !ext_edge) |-> !advance)
        else $error("counter mode stepped without edge");

    a_instr_only: assert property (@(posedge CLK) disable iff (RST)
        (!css && !INSTR_CYCLE) |-> !advance)
        else $error("timer mode stepped without cycle");

    a_reset_values: assert property (@(posedge CLK)
        RST |=>
        (s.option == TMPS_OPTION_RESET && s.count == 8'h00 && !IRQ))
        else $error("reset values wrong");

    a_count_wr_ext: assert property (@(posedge CLK) disable iff (RST)
        (count_wr && css) |=> s.count == $past(WDATA))
        else $error("count write lost in counter mode");
endmodule : tmps_timer
`default_nettype wire

/* File: pkg/tmps_pkg.sv */
package tmps_pkg;
    localparam logic [7:0] TMPS_ADDR_COUNT = 8'h01;
    localparam logic [7:0] TMPS_ADDR_INTCTL = 8'h0B;
    localparam logic [7:0] TMPS_ADDR_INTCTL_HI = 8'h8B;
    localparam logic [7:0] TMPS_ADDR_OPTION = 8'h81;
    localparam logic [7:0] TMPS_ADDR_PORTA_DIR = 8'h85;
    localparam logic [7:0] TMPS_ADDR_INT_STATUS = 8'hF0;
    localparam logic [7:0] TMPS_ADDR_INT_ENABLE = 8'hF1;
    localparam logic [7:0] TMPS_ADDR_INT_CLEAR = 8'hF2;
    localparam int TMPS_CSS_BIT = 5;
    localparam int TMPS_EDGE_BIT = 4;
    localparam int TMPS_PSA_BIT = 3;
    localparam int TMPS_OVF_FLAG_BIT = 2;
    localparam int TMPS_OVF_IE_BIT = 5;
    localparam logic [7:0] TMPS_OPTION_RESET = 8'hFF;
    localparam logic [7:0] TMPS_INTCTL_RESET = 8'h00;
    localparam logic [5:0] TMPS_PORTA_DIR_RESET = 6'h3F;
    localparam logic [1:0] TMPS_INHIBIT_CYCLES = 2'h2;
    localparam logic [7:0] TMPS_COUNT_MAX = 8'hFF;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmps_bus_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] prescale;
        logic [7:0] option;
        logic [7:0] intctl;
        logic [5:0] porta_dir;
        logic [1:0] inhibit;
        logic [2:0] ext_sync;
        logic [7:0] rdata;
        logic irq_status;
        logic irq_enable;
        logic wdt_tick;
        logic wdt_clear;
    } tmps_state_t;
endpackage : tmps_pkg

/* File: bench/tmps_ext_source.sv */
`timescale 1ns/1ps
`default_nettype none
module tmps_ext_source (
    input wire logic CLK,
    input wire logic run,
    input wire logic [3:0] half,
    output logic pin
);
    logic [3:0] cnt = 4'h0;
    initial pin = 1'b0;
    // pin stands still between bursts; half >= 2 keeps each level
    // wider than the synchronizer window
    always @(posedge CLK) begin
        if (run && cnt >= half) begin
            pin <= ~pin;
            cnt <= 4'h0;
        end else if (run) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : tmps_ext_source
`default_nettype wire

/* File: bench/test_timer0_with_shared_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module test_timer0_with_shared_prescaler
    import tmps_pkg::*;
;
    logic clk = 0, rst = 1, ic = 0, slp = 0, wbt = 0, wcl = 0;
    logic wr = 0, rd = 0, run = 0, pin, pin_q = 0, wtk, wclr, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, c1;
    logic [3:0] half = 4'h2;
    logic [31:0] seed = 32'hF216;
    int err_count = 0, num_checks = 0, rises = 0, falls = 0;
    int wticks = 0, wclrs = 0, n, e;
    tmps_timer i_tmps_timer (.CLK(clk), .RST(rst), .INSTR_CYCLE(ic),
        .SLEEP(slp), .EXT_COUNT_INPUT(pin), .WDT_BASE_TICK(wbt),
        .WATCHDOG_CLEAR_INSTR(wcl), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .WDT_TICK(wtk), .WDT_CLEAR(wclr),
        .IRQ(irq));
    tmps_ext_source i_tmps_ext_source (.CLK(clk), .run(run),
        .half(half), .pin(pin));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        pin_q <= pin;
        if (pin && !pin_q) rises++;
        if (!pin && pin_q) falls++;
        if (wtk === 1'b1) wticks++;
        if (wclr === 1'b1) wclrs++;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // timer side divides by 2^(ps+1), watchdog side by 2^ps
    function automatic int ratio(input logic prescaler_assign, input int ps);
        return prescaler_assign ? (1 << ps) : (2 << ps);
    endfunction : ratio
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 v = rdata;
        @(posedge clk);
    endtask : rd_reg
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd_reg(a, v);
        chk(v, exp);
    endtask : rchk
    task automatic irq_chk(input logic exp);
        @(posedge clk);
        #1 chk({7'h00, irq}, {7'h00, exp});
        @(posedge clk);
    endtask : irq_chk
    task automatic tick(input int k);
        repeat (k) begin
            ic <= 1;
            wbt <= 1;
            @(posedge clk);
            ic <= 0;
            wbt <= 0;
            @(posedge clk);
        end
    endtask : tick
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #(25 * 30000);
        err_count++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rchk(8'h81, 8'hFF);
        rchk(8'h0B, 8'h00);
        rchk(8'h85, 8'h3F);
        rchk(8'h33, 8'h00);
        wr_reg(8'h81, 8'h08);
        wr_reg(8'h01, 8'hFE);
        tick(2);
        rchk(8'h01, 8'hFE);
        tick(1);
        rchk(8'h01, 8'hFF);
        rchk(8'h0B, 8'h00);
        tick(1);
        rchk(8'h01, 8'h00);
        rchk(8'h0B, 8'h04);
        irq_chk(0);
        wr_reg(8'h0B, 8'h24);
        irq_chk(1);
        tick(3);
        rchk(8'h0B, 8'h24);
        wr_reg(8'h0B, 8'h20);
        irq_chk(0);
        rchk(8'hF0, 8'h01);
        wr_reg(8'hF1, 8'h01);
        irq_chk(1);
        wr_reg(8'hF2, 8'h01);
        rchk(8'hF0, 8'h00);
        irq_chk(0);
        for (int ps = 0; ps < 8; ps++) begin
            wr_reg(8'h81, {5'h00, ps[2:0]});
            n = int'(xs() % 3) + 1;
            rd_reg(8'h01, c1);
            e = wticks;
            tick(n * ratio(1'b0, ps));
            rchk(8'h01, 8'(c1 + n));
            chk(8'(wticks - e), 8'h00);
        end
        // empty the prescaler before handing it to the watchdog
        wr_reg(8'h01, 8'h00);
        tick(2);
        for (int ps = 0; ps < 8; ps++) begin
            wr_reg(8'h81, {5'h01, ps[2:0]});
            e = wclrs;
            wcl <= 1;
            @(posedge clk);
            wcl <= 0;
            repeat (2) @(posedge clk);
            chk(8'(wclrs - e), 8'h01);
            e = wticks;
            rd_reg(8'h01, c1);
            tick(2 * ratio(1'b1, ps));
            @(posedge clk);
            chk(8'(wticks - e), 8'h02);
            rchk(8'h01, 8'(c1 + 2 * ratio(1'b1, ps)));
        end
        wr_reg(8'h81, 8'h08);
        slp <= 1;
        rd_reg(8'h01, c1);
        tick(5);
        rchk(8'h01, c1);
        slp <= 0;
        tick(5);
        rchk(8'h01, 8'(c1 + 5));
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h81, m[0] ? 8'h38 : 8'h28);
            half <= 4'(2 + xs() % 8);
            rd_reg(8'h01, c1);
            e = m[0] ? falls : rises;
            run <= 1;
            repeat (30 + xs() % 40) @(posedge clk);
            run <= 0;
            repeat (6) @(posedge clk);
            n = (m[0] ? falls : rises) - e;
            rchk(8'h01, 8'(c1 + n));
        end
        summarize();
    end
endmodule : test_timer0_with_shared_prescaler
`default_nettype wire
